/* File: src/rx_pkg.sv */
`default_nettype none
package rx_pkg;
	// register byte offsets on the plain port
	localparam logic [7:0] OFF_RX_STATUS_CTRL  = 8'h00;
	localparam logic [7:0] OFF_TX_STATUS_CTRL  = 8'h01;
	localparam logic [7:0] OFF_RATE_CTRL       = 8'h02;
	localparam logic [7:0] OFF_PERIPH_ENABLES  = 8'h03;
	localparam logic [7:0] OFF_PERIPH_FLAGS    = 8'h04;
	localparam logic [7:0] OFF_IRQ_CTRL        = 8'h05;
	localparam logic [7:0] OFF_RECEIVE_DATA    = 8'h06;
	localparam logic [7:0] OFF_RATE_DIVISOR    = 8'h07;

	// receive_status_control fields
	localparam int BIT_PORT_ENABLE   = 7;
	localparam int BIT_NINE_SELECT   = 6;
	localparam int BIT_CONT_RX_EN    = 4;
	localparam int BIT_ADDR_DETECT   = 3;
	localparam int BIT_STOP_ERR      = 2;
	localparam int BIT_OVERFLOW_ERR  = 1;
	localparam int BIT_NINTH_RX      = 0;
	localparam logic [7:0] RSC_WR_MASK = 8'hF8;
	// other control fields
	localparam int BIT_CLOCKED_MODE  = 4;
	localparam int BIT_RX_IDLE       = 6;
	localparam int BIT_RX_IRQ_EN     = 5;
	localparam int BIT_RX_PENDING    = 5;
	localparam int BIT_GLOBAL_IRQ    = 7;
	localparam int BIT_PERIPH_IRQ    = 6;

	// reset values
	localparam logic [7:0] RST_REG8    = 8'h00;
	localparam logic [7:0] RST_DIVISOR = 8'h0F;

	// oversampling counts in ticks of the 16x sample clock, last data bit numbers, queue depth in entries
	localparam logic [3:0] START_DECIDE = 4'h7;
	localparam logic [3:0] BIT_DECIDE   = 4'hF;
	localparam logic [3:0] LAST_BIT_8   = 4'h7;
	localparam logic [3:0] LAST_BIT_9   = 4'h8;
	localparam logic [1:0] FIFO_DEPTH   = 2'h2;

	typedef enum logic [1:0] {ph_idle, ph_start, ph_data, ph_stop} rx_phase_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic       fe;
		logic [8:0] data;
	} rx_entry_s;
endpackage : rx_pkg
`default_nettype wire

/* File: src/async_serial_receiver.sv */
// Function
// - 16x oversampling, shifter advances once per bit
// - finished characters enter two-entry queue
// - falling edge on line starts character
// - false start at half bit silently abandoned
// - bit centres every bit, majority vote
// - low stop sample marks framing error
// - push and pending right after stop
// - data read returns oldest, pops queue
// - pending follows enabled and queue occupied
// - interrupt needs all three enables set
// - framing error per entry, head visible
// - port disable clears error status
// - framing error never stops reception
// - third character with full queue overruns
// - overrun cleared by receive or port disable
// - nine-bit mode, ninth bit of head shown
// - address mode, with nine-bit mode on, keeps only ninth-bit-set characters
`default_nettype none
module async_serial_receiver
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            srst,
	// serial line
	input  wire logic            serial_in_pin,
	// register port
	input  wire rx_pkg::bus_req_s bus_req,
	output logic [7:0]           rdata,
	// interrupt side
	output logic                 receive_pending_flag,
	output logic                 receive_irq
);
	import rx_pkg::*;

	typedef struct packed {
		logic                  line_meta;
		logic                  line_sync;
		logic                  line_prev;
		logic [7:0]            tick_cnt;
		rx_phase_e             phase;
		logic [3:0]            tcnt;
		logic [2:0]            smp;
		logic [3:0]            bitn;
		logic [8:0]            shifter;
		rx_entry_s [1:0]       ent;
		logic                  head;
		logic [1:0]            count;
		logic                  overrun;
		logic [7:0]            rsc;
		logic [7:0]            tsc;
		logic [7:0]            rate;
		logic [7:0]            pen;
		logic [7:0]            pfl;
		logic [7:0]            irqc;
		logic [7:0]            div;
		logic [7:0]            rdata;
	} rx_state_s;

	rx_state_s st_ff;
	rx_state_s nxt_st;

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : majority

	logic      port_enable;
	logic      continuous_receive_enable;
	logic      nine_bit_select;
	logic      addr_detect_on;
	logic      rx_on;
	logic      tick;
	logic      vote;
	logic      done;
	logic      accept;
	logic      pop;
	logic      push;
	logic      tail;
	rx_entry_s ch;
	rx_entry_s head_ent;

	assign port_enable               = st_ff.rsc[BIT_PORT_ENABLE];
	assign continuous_receive_enable = st_ff.rsc[BIT_CONT_RX_EN];
	assign nine_bit_select           = st_ff.rsc[BIT_NINE_SELECT];
	assign addr_detect_on            = st_ff.rsc[BIT_ADDR_DETECT];
	assign tail                      = st_ff.head ^ st_ff.count[0];
	// empty queue shows zero status, so port disable clears it
	assign head_ent = (st_ff.count != 2'h0) ? st_ff.ent[st_ff.head] : '0;
	assign receive_pending_flag = port_enable
		&& (st_ff.count != 2'h0);
	assign receive_irq = receive_pending_flag
		&& st_ff.pen[BIT_RX_IRQ_EN]
		&& st_ff.irqc[BIT_PERIPH_IRQ]
		&& st_ff.irqc[BIT_GLOBAL_IRQ];
	assign rdata = st_ff.rdata;

	always_comb begin
		nxt_st = st_ff;
		tick   = 1'b0;
		vote   = 1'b0;
		done   = 1'b0;
		accept = 1'b0;
		push   = 1'b0;
		ch     = '0;
		// two flops before the line is looked at
		nxt_st.line_meta = serial_in_pin;
		nxt_st.line_sync = st_ff.line_meta;
		nxt_st.line_prev = st_ff.line_sync;
		rx_on = port_enable && continuous_receive_enable
			&& !st_ff.tsc[BIT_CLOCKED_MODE] && !st_ff.overrun;
		// 16x sample tick from the divisor
		if (st_ff.tick_cnt == st_ff.div) begin
			nxt_st.tick_cnt = 8'h00;
			tick = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 8'h01;
		end
		vote = majority({st_ff.smp[1:0], st_ff.line_sync});
		case (st_ff.phase)
			ph_idle: begin
				if (rx_on && st_ff.line_prev && !st_ff.line_sync) begin
					nxt_st.phase    = ph_start;
					nxt_st.tcnt     = 4'h0;
					nxt_st.smp      = 3'h0;
					nxt_st.tick_cnt = 8'h00;
				end
			end
			ph_start: begin
				if (tick) begin
					nxt_st.smp  = {st_ff.smp[1:0], st_ff.line_sync};
					nxt_st.tcnt = st_ff.tcnt + 4'h1;
					if (st_ff.tcnt == START_DECIDE) begin
						nxt_st.tcnt = 4'h0;
						nxt_st.bitn = 4'h0;
						// no error raised for a glitch
						nxt_st.phase = vote ? ph_idle : ph_data;
					end
				end
			end
			ph_data: begin
				if (tick) begin
					nxt_st.smp  = {st_ff.smp[1:0], st_ff.line_sync};
					nxt_st.tcnt = st_ff.tcnt + 4'h1;
					if (st_ff.tcnt == BIT_DECIDE) begin
						nxt_st.shifter = {vote, st_ff.shifter[8:1]};
						nxt_st.bitn = st_ff.bitn + 4'h1;
						if (st_ff.bitn == (nine_bit_select ?
								LAST_BIT_9 : LAST_BIT_8)) begin
							nxt_st.phase = ph_stop;
						end
					end
				end
			end
			ph_stop: begin
				if (tick) begin
					nxt_st.smp  = {st_ff.smp[1:0], st_ff.line_sync};
					nxt_st.tcnt = st_ff.tcnt + 4'h1;
					if (st_ff.tcnt == BIT_DECIDE) begin
						done = 1'b1;
						ch.fe = !vote;
						ch.data = nine_bit_select ? st_ff.shifter
							: {1'b0, st_ff.shifter[8:1]};
						nxt_st.phase = ph_idle;
					end
				end
			end
			default: nxt_st.phase = ph_idle;
		endcase
		// a character cut off by disable is dropped, never queued
		if (!rx_on) begin
			nxt_st.phase = ph_idle;
			done         = 1'b0;
		end

		// register port
		pop = bus_req.rd && (bus_req.addr == OFF_RECEIVE_DATA)
			&& (st_ff.count != 2'h0);
		nxt_st.rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFF_RX_STATUS_CTRL: nxt_st.rdata = (st_ff.rsc & RSC_WR_MASK)
					| {5'h00, head_ent.fe, st_ff.overrun,
					head_ent.data[8]};
				OFF_TX_STATUS_CTRL: nxt_st.rdata = st_ff.tsc;
				OFF_RATE_CTRL: nxt_st.rdata = st_ff.rate
					| ({7'h00, st_ff.phase == ph_idle} << BIT_RX_IDLE);
				OFF_PERIPH_ENABLES: nxt_st.rdata = st_ff.pen;
				OFF_PERIPH_FLAGS: nxt_st.rdata = st_ff.pfl
					| ({7'h00, receive_pending_flag} << BIT_RX_PENDING);
				OFF_IRQ_CTRL: nxt_st.rdata = st_ff.irqc;
				OFF_RECEIVE_DATA: nxt_st.rdata = head_ent.data[7:0];
				OFF_RATE_DIVISOR: nxt_st.rdata = st_ff.div;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		if (bus_req.wr) begin
			case (bus_req.addr)
				// error and ninth-bit fields are status only
				OFF_RX_STATUS_CTRL: nxt_st.rsc = bus_req.wdata & RSC_WR_MASK;
				OFF_TX_STATUS_CTRL: nxt_st.tsc = bus_req.wdata;
				OFF_RATE_CTRL: nxt_st.rate = bus_req.wdata
					& ~(8'h01 << BIT_RX_IDLE);
				OFF_PERIPH_ENABLES: nxt_st.pen = bus_req.wdata;
				// pending bit cannot be written
				OFF_PERIPH_FLAGS: nxt_st.pfl = bus_req.wdata
					& ~(8'h01 << BIT_RX_PENDING);
				OFF_IRQ_CTRL: nxt_st.irqc = bus_req.wdata;
				OFF_RATE_DIVISOR: nxt_st.div = bus_req.wdata;
				default: ;
			endcase
		end

		// queue: a pop frees the slot a same-cycle push needs
		accept = !(addr_detect_on && nine_bit_select) || ch.data[8];
		if (done && accept) begin
			if (st_ff.count == FIFO_DEPTH && !pop) begin
				nxt_st.overrun = 1'b1;
			end else begin
				push = 1'b1;
			end
		end
		if (push) begin
			nxt_st.ent[tail] = ch;
		end
		if (pop) begin
			nxt_st.head = !st_ff.head;
		end
		nxt_st.count = st_ff.count + {1'b0, push} - {1'b0, pop};
		if (!continuous_receive_enable) begin
			nxt_st.overrun = 1'b0;
		end
		if (!port_enable) begin
			nxt_st.count   = 2'h0;
			nxt_st.head    = 1'b0;
			nxt_st.overrun = 1'b0;
			nxt_st.phase   = ph_idle;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff       <= '0;
			st_ff.phase <= ph_idle;
			st_ff.smp   <= 3'h7;
			st_ff.rsc   <= RST_REG8;
			st_ff.tsc   <= RST_REG8;
			st_ff.rate  <= RST_REG8;
			st_ff.pen   <= RST_REG8;
			st_ff.pfl   <= RST_REG8;
			st_ff.irqc  <= RST_REG8;
			st_ff.div   <= RST_DIVISOR;
			st_ff.rdata <= RST_REG8;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence data_read_s;
		bus_req.rd && bus_req.addr == OFF_RECEIVE_DATA
			&& st_ff.count != 2'h0 && !push && port_enable;
	endsequence
	sequence false_start_s;
		st_ff.phase == ph_start && tick && st_ff.tcnt == START_DECIDE
			&& vote && rx_on;
	endsequence
	sequence bit_hold_s;
		st_ff.phase == ph_data && !(tick && st_ff.tcnt == BIT_DECIDE);
	endsequence
	sequence stop_entry_s;
		st_ff.phase == ph_data ##1 st_ff.phase == ph_stop;
	endsequence

	pending_level_a: assert property (
		receive_pending_flag == (port_enable && st_ff.count != 2'h0))
		else $error("pending flag does not follow queue");
	pending_rise_a: assert property (
		$rose(receive_pending_flag) |-> $past(push))
		else $error("pending flag rose without a queued character");
	pending_fall_a: assert property (
		$fell(receive_pending_flag) |-> $past(pop) || !port_enable)
		else $error("pending flag fell with characters unread");
	irq_gate_a: assert property (
		receive_irq |-> st_ff.pen[BIT_RX_IRQ_EN]
			&& st_ff.irqc[BIT_PERIPH_IRQ] && st_ff.irqc[BIT_GLOBAL_IRQ])
		else $error("interrupt without all enables");
	false_start_a: assert property (
		false_start_s |=> st_ff.phase == ph_idle && !st_ff.overrun
			&& st_ff.count == $past(st_ff.count) - {1'b0, $past(pop)})
		else $error("false start not abandoned quietly");
	read_pop_a: assert property (
		data_read_s |=> st_ff.count == $past(st_ff.count) - 2'h1
			&& rdata == $past(head_ent.data[7:0])
			&& st_ff.head != $past(st_ff.head))
		else $error("data read did not pop the oldest character");
	overrun_hold_a: assert property (
		st_ff.overrun && continuous_receive_enable && port_enable
			|=> st_ff.overrun && st_ff.phase == ph_idle)
		else $error("overrun lost or reception continued");
	overrun_clear_a: assert property (
		!continuous_receive_enable || !port_enable |=> !st_ff.overrun)
		else $error("overrun not cleared by disable");
	port_flush_a: assert property (
		!port_enable |=> st_ff.count == 2'h0 && !head_ent.fe
			&& st_ff.phase == ph_idle)
		else $error("port disable did not flush");
	push_done_a: assert property (
		done && accept && st_ff.count != FIFO_DEPTH && port_enable
			&& !pop |=> st_ff.count == $past(st_ff.count) + 2'h1
			&& receive_pending_flag)
		else $error("character not queued after stop bit");
	addr_filter_a: assert property (
		done && addr_detect_on && nine_bit_select && !ch.data[8]
			|=> st_ff.count == $past(st_ff.count) - {1'b0, $past(pop)})
		else $error("address filter let a character through");
	depth_a: assert property (
		st_ff.count <= FIFO_DEPTH)
		else $error("queue count beyond two");
	shift_rate_a: assert property (
		bit_hold_s |=> $stable(st_ff.bitn) && $stable(st_ff.shifter))
		else $error("shifter moved between bit centres");
	bit_count_a: assert property (
		stop_entry_s |-> st_ff.bitn == ($past(nine_bit_select)
			? LAST_BIT_9 : LAST_BIT_8) + 4'h1)
		else $error("wrong number of data bits before stop");
	start_window_a: assert property (
		st_ff.phase == ph_start |-> st_ff.tcnt <= START_DECIDE)
		else $error("start check later than half a bit");
	fe_keep_a: assert property (
		!continuous_receive_enable && port_enable && !pop
			|=> $stable(head_ent))
		else $error("receive disable changed head status");
	overrun_block_a: assert property (
		st_ff.overrun && port_enable
			|=> st_ff.count <= $past(st_ff.count))
		else $error("character queued during overrun");
	rdata_idle_a: assert property (
		!bus_req.rd |=> rdata == 8'h00)
		else $error("read data held past its cycle");
endmodule : async_serial_receiver
`default_nettype wire

/* File: bench/serial_tx_model.sv */
`default_nettype none
module serial_tx_model #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input  wire logic clk,
	// serial line, idles high like a pulled-up wire
	output logic      line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial line = 1'b1;

	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask : hold

	// stop_ok low sends a bad stop bit on purpose
	task automatic send(input logic [8:0] d, input logic nine,
		input logic stop_ok);
		int i;
		@(posedge clk);
		hold(1'b0, BIT_CLKS); // start bit always low
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			hold(d[i], BIT_CLKS); // lsb first, whole bit
		end
		hold(stop_ok, BIT_CLKS); // stop bit
		hold(1'b1, BIT_CLKS);
	endtask : send

	// low far shorter than half a bit
	task automatic glitch();
		@(posedge clk);
		hold(1'b0, 4);
		hold(1'b1, 2 * BIT_CLKS);
	endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

/* File: bench/async_serial_receiver_tb.sv */
`default_nettype none
`define chk(n, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		$display("wrong value %s exp %h got %h", n, e, g); \
		mismatches++; \
	end \
end
module async_serial_receiver_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rx_pkg::*;

	logic             clk;
	logic             srst;
	logic             serial_in_pin;
	rx_pkg::bus_req_s bus_req;
	logic [7:0]       rdata;
	logic             receive_pending_flag;
	logic             receive_irq;
	int               mismatches = 0;
	int               tests_run = 0;

	async_serial_receiver i_dut (.clk(clk), .srst(srst),
		.serial_in_pin(serial_in_pin), .bus_req(bus_req), .rdata(rdata),
		.receive_pending_flag(receive_pending_flag),
		.receive_irq(receive_irq));
	// divisor 0 gives 16 clocks a bit
	serial_tx_model #(.BIT_CLKS(16)) i_tx (.clk(clk), .line(serial_in_pin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// one idle cycle after each strobe avoids double assignment
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(posedge clk);
		// answer still stands until this edge's update lands
		`chk(n, e, rdata);
	endtask : rd

	task automatic wait_pend();
		int i;
		for (i = 0; i < 600 && receive_pending_flag !== 1'b1; i++) begin
			@(posedge clk);
		end
		if (i == 600) begin
			mismatches++;
			test_done();
		end
	endtask : wait_pend

	initial begin
		int i;
		logic [7:0] d;
		logic [7:0] e;
		bus_req = '0;
		srst = 1'b1;
		void'($urandom(41));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(OFF_RX_STATUS_CTRL, RST_REG8, "status rst");
		rd(OFF_RATE_DIVISOR, RST_DIVISOR, "divisor rst");
		rd(8'h0F, 8'h00, "unmapped");
		wr(OFF_RX_STATUS_CTRL, 8'h07);
		rd(OFF_RX_STATUS_CTRL, 8'h00, "status ro");
		wr(OFF_PERIPH_FLAGS, 8'h20);
		rd(OFF_PERIPH_FLAGS, 8'h00, "pending ro");
		rd(OFF_RATE_CTRL, 8'h40, "rx idle");
		wr(OFF_RATE_DIVISOR, 8'h00);
		wr(OFF_TX_STATUS_CTRL, 8'h00);
		wr(OFF_PERIPH_ENABLES, 8'h20);
		wr(OFF_RX_STATUS_CTRL, 8'h90);
		repeat (3) @(posedge clk);
		$display("registers done");
		for (i = 0; i < 6; i++) begin
			d = 8'($urandom);
			// first pass forces every enable on
			e = (i == 0) ? 8'hC0 : 8'($urandom) & 8'hC0;
			wr(OFF_IRQ_CTRL, e);
			i_tx.send({1'b0, d}, 1'b0, 1'b1);
			wait_pend();
			`chk("irq", (e == 8'hC0), receive_irq);
			rd(OFF_RX_STATUS_CTRL, 8'h90, "status");
			rd(OFF_RECEIVE_DATA, d, "data");
			`chk("pending", 1'b0, receive_pending_flag);
		end
		$display("random characters done");
		i_tx.glitch();
		`chk("false start", 1'b0, receive_pending_flag);
		$display("false start done");
		i_tx.send(9'h0A5, 1'b0, 1'b0);
		i_tx.send(9'h03C, 1'b0, 1'b1);
		i_tx.send(9'h0FF, 1'b0, 1'b1);
		i_tx.send(9'h011, 1'b0, 1'b1);
		rd(OFF_RX_STATUS_CTRL, 8'h96, "overrun");
		rd(OFF_RECEIVE_DATA, 8'hA5, "oldest");
		rd(OFF_RX_STATUS_CTRL, 8'h92, "next fe");
		rd(OFF_RECEIVE_DATA, 8'h3C, "second");
		rd(OFF_RECEIVE_DATA, 8'h00, "blocked");
		wr(OFF_RX_STATUS_CTRL, 8'h80);
		rd(OFF_RX_STATUS_CTRL, 8'h80, "overrun clr");
		wr(OFF_RX_STATUS_CTRL, 8'h90);
		repeat (3) @(posedge clk);
		$display("overrun done");
		wr(OFF_RX_STATUS_CTRL, 8'hD8);
		i_tx.send(9'h055, 1'b1, 1'b1);
		`chk("addr drop", 1'b0, receive_pending_flag);
		i_tx.send(9'h1AB, 1'b1, 1'b1);
		rd(OFF_RX_STATUS_CTRL, 8'hD9, "ninth");
		rd(OFF_RECEIVE_DATA, 8'hAB, "addr data");
		wr(OFF_RX_STATUS_CTRL, 8'hD0);
		i_tx.send(9'h066, 1'b1, 1'b1);
		rd(OFF_RX_STATUS_CTRL, 8'hD0, "ninth low");
		rd(OFF_RECEIVE_DATA, 8'h66, "msg data");
		$display("nine bit done");
		wr(OFF_RX_STATUS_CTRL, 8'h90);
		wr(OFF_TX_STATUS_CTRL, 8'h10);
		i_tx.send(9'h05A, 1'b0, 1'b1);
		`chk("clocked mode", 1'b0, receive_pending_flag);
		wr(OFF_TX_STATUS_CTRL, 8'h00);
		i_tx.send(9'h0C3, 1'b0, 1'b0);
		wr(OFF_RX_STATUS_CTRL, 8'h80);
		rd(OFF_RX_STATUS_CTRL, 8'h84, "fe kept");
		wr(OFF_RX_STATUS_CTRL, 8'h00);
		rd(OFF_RX_STATUS_CTRL, 8'h00, "fe forced");
		`chk("flushed", 1'b0, receive_pending_flag);
		rd(OFF_RECEIVE_DATA, 8'h00, "flush data");
		$display("port disable done");
		test_done();
	end
endmodule : async_serial_receiver_tb
`default_nettype wire
